// ---- logic/pie_bus_slave.sv ----
`timescale 1ns/10ps
module pie_bus_slave
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pie_bus_req_type req_q
);

  pie_bus_req_type req_d;

  // ==========================================================================
  // register the request so decode runs from flops
  // ==========================================================================
  always_comb begin
    req_d.addr = reg_addr;
    req_d.wdata = reg_wdata;
    req_d.wr = reg_wr;
    req_d.rd = reg_rd & ~reg_wr;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

endmodule : pie_bus_slave

// ---- logic/pie_flag_bit.sv ----
`timescale 1ns/10ps
module pie_flag_bit
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag_q
);

  logic flag_d;

  // set wins over a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (clr_pulse) begin
      flag_d = 1'b0;
    end
    if (set_pulse) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : pie_flag_bit

// ---- logic/pie_irq_gate.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - no peripheral request reaches the processor while the group enable is clear.
// - the enable register is fully read/write and clears to zero on every reset.
// - bit 7 enables the timer gate acquisition interrupt.
// - bit 6 enables the converter completion interrupt.
// - bit 5 enables the serial receive interrupt.
// - bit 4 enables the serial transmit interrupt.
// - bit 3 enables the synchronous serial port interrupt.
// - bit 2 enables the capture/compare interrupt.
// - bit 1 enables the timer period match interrupt.
// - bit 0 enables the timer overflow interrupt.
// - global enable at control bit 7 blocks cpu_irq_req_q when clear; block_irq_q is not gated by it.
// - group enable at control bit 6 permits enabled peripheral requests when set.
// - a request flag sets on its event whatever the enables hold.
module pie_irq_gate
  import pie_pkg::*;
#(
  parameter int NUM_SRC = 8
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic [NUM_SRC-1:0] periph_event,
  output logic [NUM_SRC-1:0] periph_flags_q,
  output logic cpu_irq_req_q,
  output logic block_irq_q
);

  // ==========================================================================
  // bus front end
  // ==========================================================================
  // the request is registered once, so a write lands two edges after its strobe
  pie_bus_req_type req;

  pie_bus_slave u_bus (
    .sys_clk(sys_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .req_q(req)
  );

  logic wr_enable;
  logic wr_control;
  logic wr_flags;
  logic wr_evt_status;
  logic wr_evt_mask;

  always_comb begin
    wr_enable = req.wr && (req.addr == PIE_ADDR_ENABLE);
    wr_control = req.wr && (req.addr == PIE_ADDR_CONTROL);
    wr_flags = req.wr && (req.addr == PIE_ADDR_FLAGS);
    wr_evt_status = req.wr && (req.addr == PIE_ADDR_EVT_STATUS);
    wr_evt_mask = req.wr && (req.addr == PIE_ADDR_EVT_MASK);
  end

  // ==========================================================================
  // enable register
  // ==========================================================================
  logic [7:0] enable_q;
  logic [7:0] enable_d;

  always_comb begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enable_q <= PIE_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ==========================================================================
  // control register, only the global and group enables are kept
  // ==========================================================================
  logic [7:0] control_q;
  logic [7:0] control_d;

  always_comb begin
    control_d = control_q;
    if (wr_control) begin
      control_d = req.wdata & ((8'h01 << PIE_BIT_GLOBAL_EN) | (8'h01 << PIE_BIT_GROUP_EN));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      control_q <= PIE_CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  // ==========================================================================
  // named enable bits
  // ==========================================================================
  logic gate_acquire_irq_en;
  logic adc_done_irq_en;
  logic serial_rx_irq_en;
  logic serial_tx_irq_en;
  logic sync_port_irq_en;
  logic capcomp_irq_en;
  logic period_match_irq_en;
  logic timer_overflow_irq_en;
  logic global_irq_enable;
  logic peripheral_group_enable;

  // one name per source keeps the gating readable against the bit map
  always_comb begin
    gate_acquire_irq_en = enable_q[PIE_BIT_GATE_ACQUIRE];
    adc_done_irq_en = enable_q[PIE_BIT_ADC_DONE];
    serial_rx_irq_en = enable_q[PIE_BIT_SERIAL_RX];
    serial_tx_irq_en = enable_q[PIE_BIT_SERIAL_TX];
    sync_port_irq_en = enable_q[PIE_BIT_SYNC_PORT];
    capcomp_irq_en = enable_q[PIE_BIT_CAPCOMP];
    period_match_irq_en = enable_q[PIE_BIT_PERIOD_MATCH];
    timer_overflow_irq_en = enable_q[PIE_BIT_TIMER_OVERFLOW];
    global_irq_enable = control_q[PIE_BIT_GLOBAL_EN];
    peripheral_group_enable = control_q[PIE_BIT_GROUP_EN];
  end

  // ==========================================================================
  // peripheral request flags
  // ==========================================================================
  logic [NUM_SRC-1:0] flag_clr;

  // software clears a flag by writing zero to it; the event wins
  always_comb begin
    flag_clr = '0;
    if (wr_flags) begin
      flag_clr = ~req.wdata[NUM_SRC-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      pie_flag_bit u_flag (
        .sys_clk(sys_clk),
        .srst(srst),
        .set_pulse(periph_event[gi]),
        .clr_pulse(flag_clr[gi]),
        .flag_q(periph_flags_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // gating
  // ==========================================================================
  logic [NUM_SRC-1:0] gated;
  logic req_d;

  always_comb begin
    gated = '0;
    gated[PIE_BIT_GATE_ACQUIRE] = periph_flags_q[PIE_BIT_GATE_ACQUIRE]
      & gate_acquire_irq_en;
    gated[PIE_BIT_ADC_DONE] = periph_flags_q[PIE_BIT_ADC_DONE]
      & adc_done_irq_en;
    gated[PIE_BIT_SERIAL_RX] = periph_flags_q[PIE_BIT_SERIAL_RX]
      & serial_rx_irq_en;
    gated[PIE_BIT_SERIAL_TX] = periph_flags_q[PIE_BIT_SERIAL_TX]
      & serial_tx_irq_en;
    gated[PIE_BIT_SYNC_PORT] = periph_flags_q[PIE_BIT_SYNC_PORT]
      & sync_port_irq_en;
    gated[PIE_BIT_CAPCOMP] = periph_flags_q[PIE_BIT_CAPCOMP]
      & capcomp_irq_en;
    gated[PIE_BIT_PERIOD_MATCH] = periph_flags_q[PIE_BIT_PERIOD_MATCH]
      & period_match_irq_en;
    gated[PIE_BIT_TIMER_OVERFLOW] = periph_flags_q[PIE_BIT_TIMER_OVERFLOW]
      & timer_overflow_irq_en;
    req_d = (|gated) & peripheral_group_enable & global_irq_enable;
  end

  // ==========================================================================
  // event mask, only the rise and fall bits exist
  // ==========================================================================
  logic [7:0] evt_mask_q;
  logic [7:0] evt_mask_d;

  always_comb begin
    evt_mask_d = evt_mask_q;
    if (wr_evt_mask) begin
      evt_mask_d = req.wdata & 8'h03;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evt_mask_q <= PIE_EVT_RESET;
    end else begin
      evt_mask_q <= evt_mask_d;
    end
  end

  // ==========================================================================
  // request state and block-level interrupt events
  // ==========================================================================
  pie_req_state_type state_q;
  pie_req_state_type state_d;
  logic [7:0] evt_status_q;
  logic [7:0] evt_status_d;
  logic block_irq_d;

  // the clear is applied first so that a rise or fall in the same cycle wins
  always_comb begin
    state_d = state_q;
    evt_status_d = evt_status_q;
    if (wr_evt_status) begin
      evt_status_d = evt_status_q & ~req.wdata;
    end
    case (state_q)
      PIE_REQ_IDLE: begin
        if (req_d) begin
          state_d = PIE_REQ_ACTIVE;
          evt_status_d[PIE_EVT_REQ_RISE] = 1'b1;
        end
      end
      PIE_REQ_ACTIVE: begin
        if (!req_d) begin
          state_d = PIE_REQ_IDLE;
          evt_status_d[PIE_EVT_REQ_FALL] = 1'b1;
        end
      end
      default: begin
        state_d = PIE_REQ_IDLE;
      end
    endcase
    block_irq_d = |(evt_status_d & evt_mask_d);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= PIE_REQ_IDLE;
      evt_status_q <= PIE_EVT_RESET;
    end else begin
      state_q <= state_d;
      evt_status_q <= evt_status_d;
    end
  end

  // ==========================================================================
  // interrupt outputs, both straight from flops
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_irq_req_q <= 1'b0;
      block_irq_q <= 1'b0;
    end else begin
      cpu_irq_req_q <= req_d;
      block_irq_q <= block_irq_d;
    end
  end

  // ==========================================================================
  // read data, valid the cycle after the read strobe
  // ==========================================================================
  // decoded from the pins so the data stand in the cycle right after the strobe
  logic [7:0] rdata_d;
  logic [3:0] rd_addr;
  logic rd_now;

  always_comb begin
    rd_addr = reg_addr;
    rd_now = reg_rd & ~reg_wr;
    rdata_d = 8'h00;
    if (rd_now) begin
      case (rd_addr)
        PIE_ADDR_ENABLE: rdata_d = enable_q;
        PIE_ADDR_CONTROL: rdata_d = control_q;
        PIE_ADDR_FLAGS: rdata_d = periph_flags_q;
        PIE_ADDR_EVT_STATUS: rdata_d = evt_status_q;
        PIE_ADDR_EVT_MASK: rdata_d = evt_mask_q;
        PIE_ADDR_STATE: rdata_d = {7'h00, state_q == PIE_REQ_ACTIVE};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : pie_irq_gate

// ---- logic/pie_pkg.sv ----
package pie_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [3:0] PIE_ADDR_ENABLE = 4'h0;
  localparam logic [3:0] PIE_ADDR_CONTROL = 4'h1;
  localparam logic [3:0] PIE_ADDR_FLAGS = 4'h2;
  localparam logic [3:0] PIE_ADDR_EVT_STATUS = 4'h3;
  localparam logic [3:0] PIE_ADDR_EVT_MASK = 4'h4;
  localparam logic [3:0] PIE_ADDR_STATE = 4'h5;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] PIE_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PIE_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PIE_EVT_RESET = 8'h00;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int PIE_BIT_GATE_ACQUIRE = 7;
  localparam int PIE_BIT_ADC_DONE = 6;
  localparam int PIE_BIT_SERIAL_RX = 5;
  localparam int PIE_BIT_SERIAL_TX = 4;
  localparam int PIE_BIT_SYNC_PORT = 3;
  localparam int PIE_BIT_CAPCOMP = 2;
  localparam int PIE_BIT_PERIOD_MATCH = 1;
  localparam int PIE_BIT_TIMER_OVERFLOW = 0;
  localparam int PIE_BIT_GLOBAL_EN = 7;
  localparam int PIE_BIT_GROUP_EN = 6;
  localparam int PIE_EVT_REQ_RISE = 0;
  localparam int PIE_EVT_REQ_FALL = 1;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pie_bus_req_type;

  typedef enum logic [1:0] {
    PIE_REQ_IDLE,
    PIE_REQ_ACTIVE
  } pie_req_state_type;

endpackage : pie_pkg

// ---- verif/pie_irq_gate_checker.sv ----
`timescale 1ns/10ps
module pie_irq_gate_checker
  import pie_pkg::*;
#(
  parameter int NUM_SRC = 8
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [NUM_SRC-1:0] periph_event,
  input wire logic [NUM_SRC-1:0] periph_flags_q,
  input wire logic cpu_irq_req_q
);
  // ==========
  // shadow of enable and control, two edges behind the strobe
  logic wr_q;
  logic fw;
  logic [3:0] a_q;
  logic [7:0] d_q;
  logic [7:0] en_m;
  logic [7:0] ctl_m;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_q <= 1'b0;
      en_m <= 8'h00;
      ctl_m <= 8'h00;
    end else begin
      wr_q <= reg_wr;
      a_q <= reg_addr;
      d_q <= reg_wdata;
      if (wr_q && a_q == PIE_ADDR_ENABLE) begin
        en_m <= d_q;
      end
      if (wr_q && a_q == PIE_ADDR_CONTROL) begin
        ctl_m <= d_q & 8'hC0;
      end
    end
  end
  assign fw = wr_q && (a_q == PIE_ADDR_FLAGS);
  // ==========
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_reset_clear;
    disable iff (1'b0) srst |=> reg_rdata_q == 8'h00 && periph_flags_q == '0 && !cpu_irq_req_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("no clear on reset");
  property p_rd_idle;
    !reg_rd |=> reg_rdata_q == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_enable;
    reg_rd && !reg_wr && reg_addr == PIE_ADDR_ENABLE |=> reg_rdata_q == $past(en_m);
  endproperty
  a_rd_enable: assert property (p_rd_enable) else $error("enable read mismatch");
  property p_flag_set;
    periph_event != '0 |=> (periph_flags_q & $past(periph_event)) == $past(periph_event);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by event");
  property p_flag_hold;
    !fw |=> (periph_flags_q & $past(periph_flags_q)) == $past(periph_flags_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_group_block;
    !ctl_m[PIE_BIT_GROUP_EN] |=> !cpu_irq_req_q;
  endproperty
  a_group_block: assert property (p_group_block) else $error("group gate open");
  property p_global_block;
    !ctl_m[PIE_BIT_GLOBAL_EN] |=> !cpu_irq_req_q;
  endproperty
  a_global_block: assert property (p_global_block) else $error("global gate open");
  property p_irq_match;
    cpu_irq_req_q == $past((|(periph_flags_q & en_m)) && ctl_m[7] && ctl_m[6]);
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("request mismatch");
  c_irq: cover property (cpu_irq_req_q);
  c_flag_wr: cover property (fw);
  c_event: cover property (periph_event != '0);
endmodule : pie_irq_gate_checker

bind pie_irq_gate pie_irq_gate_checker #(.NUM_SRC(NUM_SRC)) i_pie_irq_gate_checker (
  .sys_clk(sys_clk),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .periph_event(periph_event),
  .periph_flags_q(periph_flags_q),
  .cpu_irq_req_q(cpu_irq_req_q)
);

// ---- verif/pie_src_model.sv ----
`timescale 1ns/10ps
module pie_src_model
(
  input wire logic sys_clk,
  output logic [7:0] periph_event
);
  // ==========
  // one-cycle event pulses, idle low
  initial periph_event = 8'h00;
  task automatic fire(input logic [7:0] m);
    @(posedge sys_clk);
    periph_event <= m;
    @(posedge sys_clk);
    periph_event <= 8'h00;
  endtask : fire
endmodule : pie_src_model

// ---- verif/tb_peripheral_irq_enable_gate.sv ----
`timescale 1ns/10ps
module tb_peripheral_irq_enable_gate;
  import pie_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  logic [7:0] periph_event;
  logic [7:0] periph_flags_q;
  logic cpu_irq_req_q;
  logic block_irq_q;
  int n_errors = 0;
  int checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  pie_src_model i_pie_src_model (.sys_clk(sys_clk), .periph_event(periph_event));
  pie_irq_gate i_pie_irq_gate (
    .sys_clk(sys_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .periph_event(periph_event),
    .periph_flags_q(periph_flags_q),
    .cpu_irq_req_q(cpu_irq_req_q),
    .block_irq_q(block_irq_q)
  );
  // ==========
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e, nm);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  // ==========
  // scenarios
  task automatic t_reset();
    rd(PIE_ADDR_ENABLE, 8'h00, "enable");
    rd(PIE_ADDR_CONTROL, 8'h00, "control");
    chk(periph_flags_q, 8'h00, "flags");
  endtask : t_reset
  task automatic t_rw();
    wr(PIE_ADDR_ENABLE, 8'hA5);
    rd(PIE_ADDR_ENABLE, 8'hA5, "enable");
    wr(PIE_ADDR_ENABLE, 8'h5A);
    rd(PIE_ADDR_ENABLE, 8'h5A, "enable");
    rd(4'hF, 8'h00, "unmapped");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(PIE_ADDR_ENABLE, 8'h00, "enable after reset");
  endtask : t_rw
  task automatic t_bits();
    wr(PIE_ADDR_CONTROL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      wr(PIE_ADDR_ENABLE, 8'h01 << i);
      i_pie_src_model.fire(~(8'h01 << i));
      idle(2);
      chk(periph_flags_q, ~(8'h01 << i), "flags");
      chk({7'h00, cpu_irq_req_q}, 8'h00, "irq other");
      i_pie_src_model.fire(8'h01 << i);
      idle(2);
      chk({7'h00, cpu_irq_req_q}, 8'h01, "irq own");
      wr(PIE_ADDR_FLAGS, 8'h00);
    end
  endtask : t_bits
  task automatic t_group();
    wr(PIE_ADDR_CONTROL, 8'h00);
    wr(PIE_ADDR_ENABLE, 8'hFF);
    i_pie_src_model.fire(8'hFF);
    idle(3);
    chk({7'h00, cpu_irq_req_q}, 8'h00, "irq none");
    wr(PIE_ADDR_CONTROL, 8'h80);
    idle(3);
    chk({7'h00, cpu_irq_req_q}, 8'h00, "irq no group");
    wr(PIE_ADDR_CONTROL, 8'h40);
    idle(3);
    chk({7'h00, cpu_irq_req_q}, 8'h00, "irq no global");
    wr(PIE_ADDR_EVT_STATUS, 8'h03);
    wr(PIE_ADDR_EVT_MASK, 8'h01);
    wr(PIE_ADDR_CONTROL, 8'hC0);
    idle(4);
    chk({7'h00, cpu_irq_req_q}, 8'h01, "irq both");
    rd(PIE_ADDR_EVT_STATUS, 8'h01, "evt status");
    chk({7'h00, block_irq_q}, 8'h01, "block irq");
    wr(PIE_ADDR_EVT_MASK, 8'h00);
    idle(3);
    chk({7'h00, block_irq_q}, 8'h00, "block masked");
    wr(PIE_ADDR_EVT_MASK, 8'h01);
    idle(3);
    chk({7'h00, block_irq_q}, 8'h01, "block unmasked");
    wr(PIE_ADDR_EVT_STATUS, 8'h01);
    idle(3);
    chk({7'h00, block_irq_q}, 8'h00, "block cleared");
    rd(PIE_ADDR_STATE, 8'h01, "state");
  endtask : t_group
  task automatic t_events();
    wr(PIE_ADDR_CONTROL, 8'hFF);
    rd(PIE_ADDR_CONTROL, 8'hC0, "control bits");
    wr(PIE_ADDR_EVT_MASK, 8'hFF);
    rd(PIE_ADDR_EVT_MASK, 8'h03, "evt mask bits");
    wr(PIE_ADDR_FLAGS, 8'h0F);
    rd(PIE_ADDR_FLAGS, 8'h0F, "flags partial clear");
    wr(PIE_ADDR_CONTROL, 8'h80);
    idle(2);
    chk({7'h00, cpu_irq_req_q}, 8'h00, "irq group off");
    rd(PIE_ADDR_EVT_STATUS, 8'h02, "evt fall");
    chk({7'h00, block_irq_q}, 8'h01, "block fall");
    rd(PIE_ADDR_STATE, 8'h00, "state idle");
    // event lands on the same edge as the clear
    fork
      wr(PIE_ADDR_FLAGS, 8'h00);
      begin
        @(posedge sys_clk);
        i_pie_src_model.fire(8'h80);
      end
    join
    rd(PIE_ADDR_FLAGS, 8'h80, "flag set beats clear");
  endtask : t_events
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_bits();
    t_group();
    t_events();
    stop_test();
  end
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule : tb_peripheral_irq_enable_gate
